//--- logic/iapu_pkg.sv
package iapu_pkg;

  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned NUM_PTR      = 3;
  localparam int unsigned PTR_SEL_W    = 2;

  // Pointer register map in data space
  localparam logic [11:0] PTR0_LOW_ADDR  = 12'hFE9;
  localparam logic [11:0] PTR0_HIGH_ADDR = 12'hFEA;
  localparam logic [11:0] PTR1_LOW_ADDR  = 12'hFE1;
  localparam logic [11:0] PTR1_HIGH_ADDR = 12'hFE2;
  localparam logic [11:0] PTR2_LOW_ADDR  = 12'hFD9;
  localparam logic [11:0] PTR2_HIGH_ADDR = 12'hFDA;

  // Virtual locations per pointer: base of a block of five
  localparam logic [11:0] PTR0_VIRT_BASE = 12'hFEB;
  localparam logic [11:0] PTR1_VIRT_BASE = 12'hFE3;
  localparam logic [11:0] PTR2_VIRT_BASE = 12'hFDB;
  localparam logic [11:0] VIRT_SPAN      = 12'h005;

  // Offsets of the access modes within a block
  localparam logic [2:0] OFS_INDEXED   = 3'h0;
  localparam logic [2:0] OFS_PRE_INC   = 3'h1;
  localparam logic [2:0] OFS_POST_DEC  = 3'h2;
  localparam logic [2:0] OFS_POST_INC  = 3'h3;
  localparam logic [2:0] OFS_PLAIN     = 3'h4;

  localparam logic [11:0] PTR_RESET    = 12'h000;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  typedef enum logic [2:0] {
    IAPU_MODE_PLAIN,
    IAPU_MODE_POST_DEC,
    IAPU_MODE_POST_INC,
    IAPU_MODE_PRE_INC,
    IAPU_MODE_INDEXED
  } iapu_mode_e;

endpackage

//--- logic/iapu_calc_if.sv
`timescale 1ns/1ps
interface iapu_calc_if;
  import iapu_pkg::*;
  logic [11:0] ptr_value;
  iapu_mode_e  mode;
  logic [7:0]  working_register;
  logic [11:0] eff_addr;
  logic [11:0] next_ptr;
  logic        ptr_changes;

  modport user (output ptr_value, output mode, output working_register,
                input eff_addr, input next_ptr, input ptr_changes);
  modport calc (input ptr_value, input mode, input working_register,
                output eff_addr, output next_ptr, output ptr_changes);
endinterface

//--- logic/iapu_addr_calc.sv
`timescale 1ns/1ps
module iapu_addr_calc
  import iapu_pkg::*;
(
  iapu_calc_if.calc calc  // Pointer value and mode in, address out
);

  logic [11:0] plus_one;
  logic [11:0] minus_one;
  logic [11:0] index_ext;

  // Full-width arithmetic, wraps modulo the data space
  assign plus_one  = 12'(calc.ptr_value + 12'h001);
  assign minus_one = 12'(calc.ptr_value - 12'h001);
  assign index_ext = {{4{calc.working_register[7]}}, calc.working_register};

  // Address and pointer update per access mode
  always_comb begin
    calc.eff_addr    = calc.ptr_value;
    calc.next_ptr    = calc.ptr_value;
    calc.ptr_changes = 1'b0;
    case (calc.mode)
      IAPU_MODE_PLAIN: begin
        calc.eff_addr = calc.ptr_value;
      end
      IAPU_MODE_POST_DEC: begin
        calc.next_ptr    = minus_one;
        calc.ptr_changes = 1'b1;
      end
      IAPU_MODE_POST_INC: begin
        calc.next_ptr    = plus_one;
        calc.ptr_changes = 1'b1;
      end
      IAPU_MODE_PRE_INC: begin
        calc.eff_addr    = plus_one;
        calc.next_ptr    = plus_one;
        calc.ptr_changes = 1'b1;
      end
      IAPU_MODE_INDEXED: begin
        calc.eff_addr = 12'(calc.ptr_value + index_ext);
      end
      default: begin
        calc.eff_addr = calc.ptr_value;
      end
    endcase
  end

endmodule  // iapu_addr_calc

//--- logic/iapu_unit.sv
`timescale 1ns/1ps
//
// Summary of operation
// - Three independent 12-bit pointers, each stored as high and low bytes.
// - Plain location accesses the byte at the pointer; pointer unchanged.
// - Each pointer has five virtual locations choosing how it is used.
// - Post-decrement/increment use current value, then step pointer by one.
// - Pre-increment steps pointer first, then uses the new value.
// - Indexed address is pointer plus signed working register; both unchanged.
// - Increment and decrement act on all 12 bits, carrying into high byte.
// - Automatic pointer steps never change any status flag.
// - Indirect read landing on a virtual location returns 00h, sets zero.
// - Indirect write landing on a virtual location is dropped; a stepping mode still steps the pointer.
// - Indirect write to a pointer byte beats that pointer's pending step.
//
module iapu_unit
  import iapu_pkg::*;
(
  input  wire logic        sys_clk,           // Core clock
  input  wire logic        rst_n,             // Synchronous reset, active low
  input  wire logic        acc_valid,         // Core issues an operand access
  input  wire logic        acc_write,         // 1 write, 0 read
  input  wire logic [11:0] acc_addr,          // Operand data address
  input  wire logic [7:0]  acc_wdata,         // Write data from core
  input  wire logic [7:0]  working_register,  // Signed index source
  input  wire logic [7:0]  mem_rdata,         // Memory read data, same cycle
  output logic             mem_req,           // Memory access strobe
  output logic             mem_write,         // Memory write strobe
  output logic [11:0]      mem_addr,          // Effective data address
  output logic [7:0]       mem_wdata,         // Memory write data
  output logic             rd_valid,          // Read result ready
  output logic [7:0]       rd_data,           // Read result
  output logic             zero_flag_set,     // Force zero flag from access
  output logic [11:0]      ptr0,              // Pointer 0 value
  output logic [11:0]      ptr1,              // Pointer 1 value
  output logic [11:0]      ptr2               // Pointer 2 value
);

  //////////////////////////////////////////////////////////////////////////////
  // Pointer storage and address map

  logic [7:0]  pointer_high_byte [NUM_PTR];
  logic [7:0]  pointer_low_byte  [NUM_PTR];
  logic [11:0] indirect_pointer  [NUM_PTR];
  logic [11:0] virt_base         [NUM_PTR];
  logic [11:0] low_addr          [NUM_PTR];
  logic [11:0] high_addr         [NUM_PTR];
  logic [NUM_PTR-1:0] hit;
  logic [2:0]  hit_ofs           [NUM_PTR];

  // Base of each pointer's block of five virtual locations
  assign virt_base[0] = PTR0_VIRT_BASE;
  assign virt_base[1] = PTR1_VIRT_BASE;
  assign virt_base[2] = PTR2_VIRT_BASE;

  // Low byte register address of each pointer
  assign low_addr[0]  = PTR0_LOW_ADDR;
  assign low_addr[1]  = PTR1_LOW_ADDR;
  assign low_addr[2]  = PTR2_LOW_ADDR;

  // High byte register address of each pointer
  assign high_addr[0] = PTR0_HIGH_ADDR;
  assign high_addr[1] = PTR1_HIGH_ADDR;
  assign high_addr[2] = PTR2_HIGH_ADDR;

  // Decode which pointer block an operand address falls into
  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++) begin : g_dec
      logic [11:0] diff;
      assign indirect_pointer[g] = {pointer_high_byte[g][3:0], pointer_low_byte[g]};
      assign diff       = 12'(acc_addr - virt_base[g]);
      assign hit[g]     = (acc_addr >= virt_base[g]) && (diff < VIRT_SPAN);
      assign hit_ofs[g] = diff[2:0];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Select the addressed pointer and mode

  // Addressed pointer, whether any was addressed, and how it is used
  logic [PTR_SEL_W-1:0] sel;
  logic                 any_hit;
  iapu_mode_e           mode;

  // Operand address picks the pointer and its access mode
  always_comb begin
    sel     = '0;
    any_hit = 1'b0;
    mode    = IAPU_MODE_PLAIN;
    for (int i = 0; i < NUM_PTR; i++) begin
      if (hit[i]) begin
        sel     = PTR_SEL_W'(i);
        any_hit = 1'b1;
        case (hit_ofs[i])
          OFS_PLAIN:    mode = IAPU_MODE_PLAIN;
          OFS_POST_DEC: mode = IAPU_MODE_POST_DEC;
          OFS_POST_INC: mode = IAPU_MODE_POST_INC;
          OFS_PRE_INC:  mode = IAPU_MODE_PRE_INC;
          OFS_INDEXED:  mode = IAPU_MODE_INDEXED;
          default:      mode = IAPU_MODE_PLAIN;
        endcase
      end
    end
  end

  // One arithmetic unit serves whichever pointer the operand selects
  iapu_calc_if calc_bus ();

  // Addressed pointer, its mode and the signed index feed the arithmetic
  assign calc_bus.ptr_value        = indirect_pointer[sel];
  assign calc_bus.mode             = mode;
  assign calc_bus.working_register = working_register;  // Never written here

  // Effective address, next pointer value and whether the pointer steps
  iapu_addr_calc u_calc (
    .calc (calc_bus.calc)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Target checks on the effective address

  // Access kind and where its effective address lands
  logic ind_access;
  logic tgt_virtual;
  logic [NUM_PTR-1:0] tgt_low;
  logic [NUM_PTR-1:0] tgt_high;

  // Operand named one of the virtual locations of some pointer
  assign ind_access = acc_valid && any_hit;

  // Effective address on a virtual block or on a pointer byte
  always_comb begin
    tgt_virtual = 1'b0;
    for (int i = 0; i < NUM_PTR; i++) begin
      if ((calc_bus.eff_addr >= virt_base[i]) &&
          (12'(calc_bus.eff_addr - virt_base[i]) < VIRT_SPAN)) begin
        tgt_virtual = 1'b1;
      end
      tgt_low[i]  = (calc_bus.eff_addr == low_addr[i]);
      tgt_high[i] = (calc_bus.eff_addr == high_addr[i]);
    end
  end

  // Byte writes to pointer registers, direct or through any pointer, its own included
  logic [NUM_PTR-1:0] wr_low;
  logic [NUM_PTR-1:0] wr_high;
  logic [NUM_PTR-1:0] direct_low;
  logic [NUM_PTR-1:0] direct_high;
  logic [NUM_PTR-1:0] via_low;
  logic [NUM_PTR-1:0] via_high;

  // Direct operand names a pointer byte; an indirect target lands on one
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      direct_low[i]  = !any_hit && (acc_addr == low_addr[i]);
      direct_high[i] = !any_hit && (acc_addr == high_addr[i]);
      via_low[i]     = any_hit && tgt_low[i] && !tgt_virtual;
      via_high[i]    = any_hit && tgt_high[i] && !tgt_virtual;
    end
  end

  // Only writes touch a pointer byte; reads of them go on to memory
  always_comb begin
    for (int i = 0; i < NUM_PTR; i++) begin
      wr_low[i]  = acc_valid && acc_write && (direct_low[i] || via_low[i]);
      wr_high[i] = acc_valid && acc_write && (direct_high[i] || via_high[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointer update; no status output is touched by stepping

  generate
    for (g = 0; g < NUM_PTR; g++) begin : g_ptr
      logic step;

      // Step only the pointer that this access addresses
      assign step = ind_access && (sel == PTR_SEL_W'(g)) && calc_bus.ptr_changes;

      // Low byte: written value dominates a pending step
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pointer_low_byte[g] <= PTR_RESET[7:0];
        end else if (wr_low[g] || wr_high[g]) begin
          if (wr_low[g]) begin
            pointer_low_byte[g] <= acc_wdata;
          end
        end else if (step) begin
          pointer_low_byte[g] <= calc_bus.next_ptr[7:0];
        end
      end

      // High byte: upper four bits read as zero
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          pointer_high_byte[g] <= {4'h0, PTR_RESET[11:8]};
        end else if (wr_low[g] || wr_high[g]) begin
          if (wr_high[g]) begin
            pointer_high_byte[g] <= {4'h0, acc_wdata[3:0]};
          end
        end else if (step) begin
          pointer_high_byte[g] <= {4'h0, calc_bus.next_ptr[11:8]};
        end
      end
    end
  endgenerate

  // Pointer values straight from the byte flops
  assign ptr0 = {pointer_high_byte[0][3:0], pointer_low_byte[0]};
  assign ptr1 = {pointer_high_byte[1][3:0], pointer_low_byte[1]};
  assign ptr2 = {pointer_high_byte[2][3:0], pointer_low_byte[2]};

  //////////////////////////////////////////////////////////////////////////////
  // Memory strobes; pointer register writes and virtual targets are not passed on

  logic ptr_reg_hit;
  logic virt_block;
  logic pass_on;

  // A pointer byte write is served here and never reaches the memory
  assign ptr_reg_hit = (|(wr_low | wr_high));

  // An indirect access that lands on a virtual location is swallowed
  assign virt_block  = any_hit && tgt_virtual;

  // Everything else goes out to the data memory
  assign pass_on     = acc_valid && !virt_block && !ptr_reg_hit;

  // Request and write strobes, one cycle each
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
    end else begin
      mem_req   <= pass_on;
      mem_write <= pass_on && acc_write;
    end
  end

  // Effective address: formed by the pointer when indirect, as given otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_addr <= 12'h000;
    end else begin
      mem_addr <= any_hit ? calc_bus.eff_addr : acc_addr;
    end
  end

  // Write data follows the address so both stand in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mem_wdata <= ZERO_BYTE;
    end else begin
      mem_wdata <= acc_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read results: virtual target reads zero and forces the zero flag

  logic rd_pend;
  logic rd_zero;

  // A read is pending while memory answers the registered request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
    end else begin
      rd_pend <= acc_valid && !acc_write;
    end
  end

  // Remember that the pending read was swallowed as a virtual target
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_zero <= 1'b0;
    end else begin
      rd_zero <= acc_valid && !acc_write && virt_block;
    end
  end

  // Result strobe and zero flag pulse, one cycle each
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_valid      <= 1'b0;
      zero_flag_set <= 1'b0;
    end else begin
      rd_valid      <= rd_pend;
      zero_flag_set <= rd_pend && rd_zero;
    end
  end

  // Result byte: memory data, or all zeros for a virtual target
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data <= ZERO_BYTE;
    end else begin
      rd_data <= rd_zero ? ZERO_BYTE : mem_rdata;
    end
  end

endmodule  // iapu_unit

//--- verif/iapu_unit_checker.sv
`timescale 1ns/1ps
module iapu_unit_checker (
  input wire logic        sys_clk,          // Clock
  input wire logic        rst_n,            // Reset
  input wire logic        acc_valid,        // Access
  input wire logic        acc_write,        // Write
  input wire logic [11:0] acc_addr,         // Operand
  input wire logic [7:0]  acc_wdata,        // Data
  input wire logic [7:0]  working_register, // Index
  input wire logic        mem_req,          // Strobe
  input wire logic [11:0] mem_addr,         // Address
  input wire logic        rd_valid,         // Result
  input wire logic [7:0]  rd_data,          // Result data
  input wire logic        zero_flag_set,    // Zero
  input wire logic [11:0] ptr0              // Pointer 0
);
  logic        rd0;
  logic        wr0;
  logic [11:0] idx_addr;

  // True for any of the fifteen virtual locations
  function automatic logic virt(logic [11:0] a);
    return (a inside {[12'hFDB:12'hFDF], [12'hFE3:12'hFE7], [12'hFEB:12'hFEF]});
  endfunction

  // Access kinds and the indexed target
  assign rd0 = acc_valid && !acc_write;
  assign wr0 = acc_valid && acc_write;
  assign idx_addr = ptr0 + {{4{working_register[7]}}, working_register};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_post_inc_step: assert property (rd0 && acc_addr == 12'hFEE |=>
    ptr0 == $past(ptr0) + 12'h001) else $error("post increment step wrong");
  a_post_dec_step: assert property (rd0 && acc_addr == 12'hFED |=>
    ptr0 == $past(ptr0) - 12'h001) else $error("post decrement step wrong");
  a_plain_access: assert property (rd0 && acc_addr == 12'hFEF && !virt(ptr0) |=>
    mem_req && mem_addr == $past(ptr0) && $stable(ptr0)) else $error("plain access wrong");
  a_pre_inc_addr: assert property (rd0 && acc_addr == 12'hFEC && !virt(ptr0 + 12'h001) |=>
    mem_req && mem_addr == ptr0 && ptr0 == $past(ptr0) + 12'h001) else $error("pre inc wrong");
  a_indexed_addr: assert property (rd0 && acc_addr == 12'hFEB && !virt(idx_addr) |=>
    mem_req && mem_addr == $past(idx_addr) && $stable(ptr0)) else $error("indexed wrong");
  a_virt_read_zero: assert property (rd0 && acc_addr == 12'hFEF && virt(ptr0) |=>
    !mem_req ##1 rd_valid && zero_flag_set && rd_data == 8'h00) else $error("virtual read");
  a_virt_write_nop: assert property (wr0 && acc_addr == 12'hFEF && virt(ptr0) |=>
    !mem_req && $stable(ptr0)) else $error("virtual write not ignored");
  a_byte_write_wins: assert property (wr0 && acc_addr == 12'hFEE && ptr0 == 12'hFE9 |=>
    ptr0 == {4'hF, $past(acc_wdata)}) else $error("pointer byte write lost");
endmodule // iapu_unit_checker

bind iapu_unit iapu_unit_checker u_chk (.sys_clk, .rst_n, .acc_valid, .acc_write,
  .acc_addr, .acc_wdata, .working_register, .mem_req, .mem_addr, .rd_valid, .rd_data,
  .zero_flag_set, .ptr0);

//--- verif/iapu_mem_model.sv
`timescale 1ns/1ps
module iapu_mem_model (
  input  wire logic        sys_clk,   // Clock
  input  wire logic        mem_req,   // Strobe
  input  wire logic        mem_write, // Write
  input  wire logic [11:0] mem_addr,  // Address
  input  wire logic [7:0]  mem_wdata, // Write data
  output logic [7:0]       mem_rdata  // Read data
);
  logic [7:0] mem [0:4095];
  logic [7:0] last = 8'h00;

  // Store writes, remember the last byte read
  always_ff @(posedge sys_clk) begin
    if (mem_req && mem_write)
      mem[mem_addr] <= mem_wdata;
    if (mem_req && !mem_write)
      last <= mem[mem_addr];
  end

  // Outside a read the bus carries the inverse of the last byte
  assign mem_rdata = (mem_req && !mem_write) ? mem[mem_addr] : ~last;
endmodule // iapu_mem_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rst_n, acc_valid, acc_write, mem_req, mem_write, rd_valid;
  logic        zero_flag_set;
  logic [11:0] acc_addr, mem_addr, ptr0, ptr1, ptr2;
  logic [7:0]  acc_wdata, working_register, mem_rdata, mem_wdata, rd_data;
  int          n_errors = 0;
  int          cmp_count = 0;

  iapu_unit dut (.sys_clk, .rst_n, .acc_valid, .acc_write, .acc_addr, .acc_wdata,
    .working_register, .mem_rdata, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .rd_valid, .rd_data, .zero_flag_set, .ptr0, .ptr1, .ptr2);
  iapu_mem_model model (.sys_clk, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_rdata);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access pulse; returns just after the edge that takes it
  task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    #1;
  endtask

  // Read and judge valid, zero and data one edge after the access is taken
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic z);
    acc(1'b0, a, 8'h00);
    @(posedge sys_clk);
    #1;
    chk({2'h0, rd_valid, zero_flag_set, rd_data}, {3'h1, z, d});
  endtask

  // Load a pointer through its byte registers, high first
  task automatic set_ptr(input logic [11:0] lo, input logic [11:0] v);
    acc(1'b1, lo + 12'h001, {4'h0, v[11:8]});
    acc(1'b1, lo, v[7:0]);
  endtask

  task automatic t_plain();
    set_ptr(12'hFE9, 12'h123);
    acc(1'b1, 12'hFEF, 8'hA5);
    rd(12'hFEF, 8'hA5, 1'b0);
    chk(ptr0, 12'h123);
  endtask

  task automatic t_step();
    set_ptr(12'hFE9, 12'h0FF);
    acc(1'b1, 12'hFEE, 8'h11);
    acc(1'b1, 12'hFEE, 8'h22);
    chk(ptr0, 12'h101);
    acc(1'b1, 12'hFED, 8'h33);
    chk(ptr0, 12'h100);
    rd(12'hFEE, 8'h22, 1'b0);
    rd(12'hFED, 8'h33, 1'b0);
    rd(12'hFEC, 8'h33, 1'b0);
    chk(ptr0, 12'h101);
    rd(12'hFEB, 8'h33, 1'b0);
    set_ptr(12'hFE1, 12'h0FF);
    rd(12'hFE6, 8'h11, 1'b0);
    chk(ptr1, 12'h100);
    chk(ptr0, 12'h101);
  endtask

  task automatic t_wrap();
    set_ptr(12'hFD9, 12'hFFF);
    acc(1'b1, 12'hFDC, 8'h44);
    chk(ptr2, 12'h000);
    rd(12'hFDD, 8'h44, 1'b0);
    chk(ptr2, 12'hFFF);
  endtask

  task automatic t_index();
    set_ptr(12'hFE1, 12'h010);
    @(posedge sys_clk);
    working_register <= 8'hF0;
    rd(12'hFE3, 8'h44, 1'b0);
    @(posedge sys_clk);
    working_register <= 8'h05;
    acc(1'b1, 12'hFE3, 8'h55);
    chk(ptr1, 12'h010);
    set_ptr(12'hFE1, 12'h015);
    rd(12'hFE7, 8'h55, 1'b0);
  endtask

  task automatic t_virt();
    set_ptr(12'hFE9, 12'hFEF);
    rd(12'hFEF, 8'h00, 1'b1);
    acc(1'b1, 12'hFEF, 8'h77);
    chk({11'h0, mem_req}, 12'h000);
    chk(ptr0, 12'hFEF);
    set_ptr(12'hFE9, 12'hFE9);
    acc(1'b1, 12'hFEE, 8'h3C);
    chk(ptr0, 12'hF3C);
  endtask

  // Reset in mid-run clears every pointer; the unit works again at once
  task automatic t_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(ptr0, 12'h000);
    chk(ptr1, 12'h000);
    chk(ptr2, 12'h000);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'hFEF, 8'h44, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset for five cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 12'h000;
    acc_wdata = 8'h00;
    working_register = 8'h00;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_plain();
    t_step();
    t_wrap();
    t_index();
    t_virt();
    t_reset();
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_top
